// ==== verilog/pcgb_pkg.sv ====
// Shared constants of the second peripheral clock gate bank
package pcgb_pkg;

    // ============================================================
    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int WORD_SHIFT = 2;

    // ============================================================
    // Register indices and byte addresses (byte address = index * 4)
    localparam logic [ADDR_W-1:0] REG_GATE_IDX = 16'h1C03;
    localparam logic [ADDR_W-1:0] REG_STATUS_IDX = 16'h1C40;
    localparam logic [ADDR_W-1:0] REG_GATE_ADDR = REG_GATE_IDX << WORD_SHIFT;
    localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = REG_STATUS_IDX << WORD_SHIFT;

    // ============================================================
    // Gate register fields; a set bit stops that unit's clock
    localparam int GATE_W = 7;
    localparam int DISPLAY_BIT = 0;
    localparam int SAR_BIT = 1;
    localparam int USB_BIT = 2;
    localparam int DMA1_BIT = 3;
    localparam int DMA2_BIT = 4;
    localparam int DMA3_BIT = 5;
    localparam int ANALOG_BIT = 6;
    localparam logic [GATE_W-1:0] GATE_RESET = 7'h00;

    // ============================================================
    // Status register fields
    localparam int STAT_ACK_BIT = 0;
    localparam int STAT_RUN_LSB = 8;

    // ============================================================
    // Misc
    localparam int SYNC_STAGES = 2;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage

// ==== verilog/pcgb_gate_bank.sv ====
// Second peripheral clock gate bank with a classic Wishbone register slave
// ============================================================
// How it works
// - Each gate bit at 0 keeps its clock running; at 1 stops it.
// - Bit 6 gates the clock of the analog-domain control registers.
// - Bit 5 gates the clock of DMA controller three.
// - Bit 4 gates the clock of DMA controller two.
// - Bit 3 gates the clock of DMA controller one.
// - Bit 2 gates the USB controller clock.
// - The USB gate stops only the controller clock; the USB PLL keeps running.
module pcgb_gate_bank (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pcgb_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [pcgb_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [pcgb_pkg::DATA_W-1:0] wb_dat_i,
    output logic [pcgb_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic usb_stop_acknowledge,
    output logic analog_regs_clk_run,
    output logic third_dma_clk_run,
    output logic second_dma_clk_run,
    output logic first_dma_clk_run,
    output logic usb_controller_clk_run,
    output logic sar_converter_clk_run,
    output logic display_controller_clk_run,
    output logic usb_pll_run
);

    // ============================================================
    // State
    typedef struct packed {
        logic [pcgb_pkg::GATE_W-1:0] gate;
        logic [pcgb_pkg::GATE_W-1:0] run;
        logic pll_run;
        logic [pcgb_pkg::SYNC_STAGES-1:0] ack_sync;
        logic ack;
        logic [pcgb_pkg::DATA_W-1:0] rdata;
    } pcgb_state_t;

    pcgb_state_t st;
    pcgb_state_t next_st;

    // ============================================================
    // Address decode, used by the datapath and the checks
    function automatic logic pcgb_hit(input logic [pcgb_pkg::ADDR_W-1:0] adr,
                                      input logic [pcgb_pkg::ADDR_W-1:0] reg_addr);
        // Byte lane bits ignored: each register owns one aligned word
        pcgb_hit = (adr >> pcgb_pkg::WORD_SHIFT) == (reg_addr >> pcgb_pkg::WORD_SHIFT);
    endfunction

    logic req;
    logic hit_gate;
    logic hit_status;
    logic write_gate;
    logic read_gate;
    logic read_status;

    assign req = wb_cyc_i && wb_stb_i && !st.ack;
    assign hit_gate = pcgb_hit(wb_adr_i, pcgb_pkg::REG_GATE_ADDR);
    assign hit_status = pcgb_hit(wb_adr_i, pcgb_pkg::REG_STATUS_ADDR);
    assign write_gate = req && wb_we_i && hit_gate && wb_sel_i[0];
    assign read_gate = req && !wb_we_i && hit_gate;
    assign read_status = req && !wb_we_i && hit_status;

    // ============================================================
    // Next state
    always_comb begin
        next_st = st;
        // Acknowledge pin is asynchronous to ref_clk
        next_st.ack_sync = {st.ack_sync[pcgb_pkg::SYNC_STAGES-2:0], usb_stop_acknowledge};
        next_st.ack = 1'b0;
        next_st.rdata = pcgb_pkg::READ_ZERO;
        if (req) begin
            // Unmapped addresses still get an ack, reading zero
            next_st.ack = 1'b1;
            if (write_gate) begin
                // Upper bits of the write are dropped
                next_st.gate = wb_dat_i[pcgb_pkg::GATE_W-1:0];
            end
            if (!wb_we_i && hit_gate) begin
                next_st.rdata[pcgb_pkg::GATE_W-1:0] = st.gate;
            end
            if (!wb_we_i && hit_status) begin
                next_st.rdata[pcgb_pkg::STAT_ACK_BIT] = st.ack_sync[pcgb_pkg::SYNC_STAGES-1];
                next_st.rdata[pcgb_pkg::STAT_RUN_LSB +: pcgb_pkg::GATE_W] = st.run;
            end
        end
        // Enables track the gate in the same edge; no software ordering
        // check here, the stop handshake is the caller's duty
        next_st.run = ~next_st.gate;
        // PLL is not touched by any gate bit
        next_st.pll_run = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st.gate <= pcgb_pkg::GATE_RESET;
            st.run <= ~pcgb_pkg::GATE_RESET;
            st.pll_run <= 1'b1;
            st.ack_sync <= '0;
            st.ack <= 1'b0;
            st.rdata <= pcgb_pkg::READ_ZERO;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // Outputs, each a flip-flop; these are enables for cell-level gates
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign analog_regs_clk_run = st.run[pcgb_pkg::ANALOG_BIT];
    assign third_dma_clk_run = st.run[pcgb_pkg::DMA3_BIT];
    assign second_dma_clk_run = st.run[pcgb_pkg::DMA2_BIT];
    assign first_dma_clk_run = st.run[pcgb_pkg::DMA1_BIT];
    assign usb_controller_clk_run = st.run[pcgb_pkg::USB_BIT];
    assign sar_converter_clk_run = st.run[pcgb_pkg::SAR_BIT];
    assign display_controller_clk_run = st.run[pcgb_pkg::DISPLAY_BIT];
    assign usb_pll_run = st.pll_run;

    // ============================================================
    // Checks
    default clocking pcgb_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Every bit: written value shows inverted on the enables one edge later
    genvar gi;
    generate
        for (gi = 0; gi < pcgb_pkg::GATE_W; gi++) begin : g_bit_chk
            a_bit_write_run: assert property (
                write_gate |=> (st.run[gi] == !$past(wb_dat_i[gi])))
                else $error("gate bit write did not reach its enable");
        end
    endgenerate

    a_analog_gate_map: assert property (
        write_gate ##1 1'b1 |-> analog_regs_clk_run == !$past(wb_dat_i[pcgb_pkg::ANALOG_BIT], 1))
        else $error("analog register clock does not follow bit 6");

    a_dma3_hold: assert property (
        !write_gate |=> $stable(third_dma_clk_run))
        else $error("DMA three clock changed without a gate write");

    a_dma2_readback: assert property (
        read_gate |=> wb_ack_o && (wb_dat_o[pcgb_pkg::DMA2_BIT] == !second_dma_clk_run))
        else $error("DMA two gate readback disagrees with its enable");

    a_dma1_rise_cause: assert property (
        $rose(first_dma_clk_run) |-> $past(write_gate)
            && !$past(wb_dat_i[pcgb_pkg::DMA1_BIT]))
        else $error("DMA one clock restarted without a zero write");

    a_usb_stop_cause: assert property (
        $fell(usb_controller_clk_run) |-> $past(write_gate)
            && $past(wb_dat_i[pcgb_pkg::USB_BIT]))
        else $error("USB clock stopped without a one write to bit 2");

    a_usb_pll_alive: assert property (
        !usb_controller_clk_run |-> usb_pll_run throughout (1'b1 [*4]))
        else $error("USB PLL stopped with the controller gate");

    a_reserved_zero: assert property (
        read_gate |=> wb_dat_o[pcgb_pkg::DATA_W-1:pcgb_pkg::GATE_W] == '0)
        else $error("reserved gate bits did not read zero");

    a_ack_one_cycle: assert property (
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");

    // Per-port mapping; a swapped output would still pass the generate check
    a_third_dma_map: assert property (
        write_gate |=> third_dma_clk_run == !$past(wb_dat_i[pcgb_pkg::DMA3_BIT]))
        else $error("DMA three clock does not follow bit 5");

    a_second_dma_map: assert property (
        write_gate |=> second_dma_clk_run == !$past(wb_dat_i[pcgb_pkg::DMA2_BIT]))
        else $error("DMA two clock does not follow bit 4");

    a_first_dma_map: assert property (
        write_gate |=> first_dma_clk_run == !$past(wb_dat_i[pcgb_pkg::DMA1_BIT]))
        else $error("DMA one clock does not follow bit 3");

    a_usb_gate_map: assert property (
        write_gate |=> usb_controller_clk_run == !$past(wb_dat_i[pcgb_pkg::USB_BIT]))
        else $error("USB clock does not follow bit 2");

    a_sar_gate_map: assert property (
        write_gate |=> sar_converter_clk_run == !$past(wb_dat_i[pcgb_pkg::SAR_BIT]))
        else $error("converter clock does not follow bit 1");

    a_display_gate_map: assert property (
        write_gate |=> display_controller_clk_run == !$past(wb_dat_i[pcgb_pkg::DISPLAY_BIT]))
        else $error("display clock does not follow bit 0");

    a_lane_ignore: assert property (
        req && wb_we_i && hit_gate && !wb_sel_i[0] |=> $stable(st.gate))
        else $error("gate changed on a write without byte lane zero");

    a_unmapped_zero: assert property (
        req && !wb_we_i && !hit_gate && !hit_status |=> wb_ack_o && wb_dat_o == '0)
        else $error("unmapped read returned nonzero data");

    a_status_run_map: assert property (
        read_status |=> wb_dat_o[pcgb_pkg::STAT_RUN_LSB +: pcgb_pkg::GATE_W]
            == {analog_regs_clk_run, third_dma_clk_run, second_dma_clk_run,
                first_dma_clk_run, usb_controller_clk_run, sar_converter_clk_run,
                display_controller_clk_run})
        else $error("status run field disagrees with the enables");

    // Bus data must idle at zero so a stray sample never sees stale bits
    a_idle_data_zero: assert property (
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data not zero outside an ack");

    c_usb_stop: cover property (write_gate ##1 $fell(usb_controller_clk_run));
    c_usb_restart: cover property ($fell(usb_controller_clk_run)
        ##[1:200] $rose(usb_controller_clk_run));
    c_status_read: cover property (read_status ##1 wb_dat_o[pcgb_pkg::STAT_ACK_BIT]);
    c_all_stopped: cover property (write_gate && (&wb_dat_i[pcgb_pkg::GATE_W-1:0]));
    c_lane_ignored: cover property (req && wb_we_i && hit_gate && !wb_sel_i[0]);

endmodule // pcgb_gate_bank

// ==== test/tb_pcgb_gate_bank.sv ====
// Self-checking bench of the second clock gate bank, with a register model
module tb_pcgb_gate_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, usb_stop_acknowledge;
    logic usb_pll_run;
    logic [pcgb_pkg::ADDR_W-1:0] wb_adr_i;
    logic [pcgb_pkg::SEL_W-1:0] wb_sel_i;
    logic [pcgb_pkg::DATA_W-1:0] wb_dat_i, wb_dat_o, q;
    logic [6:0] run;
    logic [31:0] seed, gate_m, ack_m;
    logic [31:0] exp_q[$];
    int errors, check_count;
    pcgb_gate_bank dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .usb_stop_acknowledge(usb_stop_acknowledge), .analog_regs_clk_run(run[6]),
        .third_dma_clk_run(run[5]), .second_dma_clk_run(run[4]), .first_dma_clk_run(run[3]),
        .usb_controller_clk_run(run[2]), .sar_converter_clk_run(run[1]),
        .display_controller_clk_run(run[0]), .usb_pll_run(usb_pll_run));
    // ============================================================
    // Helpers
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic test_done;
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic cycle; waits for ack, then one idle cycle
    task automatic wb(input logic we, input logic [15:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            $display("Error ack expected 1 seen %b", wb_ack_o);
            test_done();
        end else begin
            // Data taken at the edge that shows ack, only then released
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
        wb(1'b1, a, s, d);
        if (a[15:2] == pcgb_pkg::REG_GATE_ADDR[15:2] && s[0]) gate_m = d & 32'h0000_007F;
        chk("run", {25'h0, ~gate_m[6:0]}, {25'h0, run});
        chk("pll", 32'h0000_0001, {31'h0, usb_pll_run});
    endtask
    task automatic rd(input logic [15:0] a);
        logic [31:0] e;
        e = 32'h0000_0000;
        if (a[15:2] == pcgb_pkg::REG_GATE_ADDR[15:2]) e = gate_m;
        if (a[15:2] == pcgb_pkg::REG_STATUS_ADDR[15:2]) e = {17'h0, ~gate_m[6:0], 7'h0, ack_m[0]};
        exp_q.push_back(e);
        wb(1'b0, a, 4'hF, xs(seed));
        chk("read", exp_q.pop_front(), q);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        errors = 0;
        check_count = 0;
        seed = 32'h0000_39F7;
        gate_m = 32'h0000_0000;
        ack_m = 32'h0000_0000;
        reset_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 16'h0000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        usb_stop_acknowledge = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        chk("reset run", 32'h0000_007F, {25'h0, run});
        rd(pcgb_pkg::REG_GATE_ADDR);
        $display("Test reset done");
        // USB gate bit is only ever set while the stop acknowledge stands
        usb_stop_acknowledge <= 1'b1;
        ack_m = 32'h0000_0001;
        repeat (4) @(posedge ref_clk);
        rd(pcgb_pkg::REG_STATUS_ADDR);
        wr(pcgb_pkg::REG_GATE_ADDR, 4'h1, 32'h0000_0004);
        rd(pcgb_pkg::REG_STATUS_ADDR);
        $display("Test usb stop done");
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            wr(pcgb_pkg::REG_GATE_ADDR, 4'hF, (seed & 32'hFFFF_FF80) | (32'h1 << i));
            rd(pcgb_pkg::REG_GATE_ADDR);
        end
        $display("Test single bits done");
        seed = xs(seed);
        wr(pcgb_pkg::REG_GATE_ADDR, 4'hE, seed);
        wr(16'h7000, 4'hF, 32'hFFFF_FFFF);
        rd(16'h7000);
        wr(pcgb_pkg::REG_STATUS_ADDR, 4'hF, 32'hFFFF_FFFF);
        rd(pcgb_pkg::REG_STATUS_ADDR);
        wr(pcgb_pkg::REG_GATE_ADDR, 4'h1, 32'hFFFF_FFFF);
        rd(pcgb_pkg::REG_GATE_ADDR);
        $display("Test ignored writes done");
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            wr(pcgb_pkg::REG_GATE_ADDR, seed[11:8], seed);
            rd(pcgb_pkg::REG_GATE_ADDR);
        end
        $display("Test random done");
        wr(pcgb_pkg::REG_GATE_ADDR, 4'h1, 32'h0000_0000);
        usb_stop_acknowledge <= 1'b0;
        ack_m = 32'h0000_0000;
        repeat (4) @(posedge ref_clk);
        rd(pcgb_pkg::REG_STATUS_ADDR);
        $display("Test usb restart done");
        test_done();
    end
endmodule // tb_pcgb_gate_bank
